/* rtl/twu_pkg.sv */
// package: register map, field positions, reset values and types of the timer/watchdog unit
package twu_pkg;
   // ----------------------------------------------------------------
   // register byte offsets (printed offsets are not all word aligned: index x4)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_EXT_IRQ_VECTOR_SELECT = 8'hf6;
   localparam logic [7:0] IDX_COUNTER_HIGH_BYTE = 8'hf8;
   localparam logic [7:0] IDX_COUNTER_LOW_BYTE = 8'hf9;
   localparam logic [7:0] IDX_PRESCALER_VALUE = 8'hfa;
   localparam logic [7:0] IDX_TIMER_CONTROL = 8'hfb;
   localparam logic [7:0] IDX_WAIT_CONTROL = 8'hfc;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'hfd;   // pending bits and mode status
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_COUNTER_BYTE = 8'hff;
   localparam logic [7:0] RST_PRESCALER = 8'hff;
   localparam logic [7:0] RST_TIMER_CONTROL = 8'h12;
   localparam logic [7:0] RST_WAIT_CONTROL = 8'h7f;
   localparam logic [7:0] RST_EXT_IRQ_VECTOR = 8'h06;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTL_RUN = 7;
   localparam int CTL_SINGLE = 6;
   localparam int CTL_MODE_HI = 5;
   localparam int CTL_MODE_LO = 4;
   localparam int CTL_INPUT_ON = 3;
   localparam int CTL_OUT_STYLE = 2;
   localparam int CTL_OUT_LEVEL = 1;
   localparam int CTL_OUT_ON = 0;
   localparam int WCR_GUARD_EN_N = 6;
   localparam int EIV_TOP_SEL = 2;
   localparam int EIV_A0_SEL = 1;
   localparam int ST_A0_PEND = 0;
   localparam int ST_TOP_PEND = 1;
   localparam int ST_GUARD_MODE = 2;
   localparam int FLAG_GUARD_RESET = 6;
   // ----------------------------------------------------------------
   // watchdog service bytes and clock divider
   // ----------------------------------------------------------------
   localparam logic [7:0] KEY_FIRST = 8'haa;
   localparam logic [7:0] KEY_SECOND = 8'h55;
   localparam int CORE_DIV = 4;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      twu_event_count, twu_gated, twu_trigger, twu_retrigger
   } twu_in_mode_e;
   typedef enum {twu_key_idle, twu_key_armed} twu_key_e;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } twu_apb_req_s;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } twu_apb_rsp_s;
endpackage

/* rtl/twu_timer_watchdog_unit.sv */
// timer/watchdog unit: prescaled 16-bit down counter, watchdog reset and interrupt routing
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
// Functional notes
// - halt stops cpu only; watchdog keeps counting
// - watchdog ignores run, single, input mode
// - interrupt request at each enabled end, none when both selects take pins
// - software pending write raises trap
// - watchdog reset sets clock flag bit 6
// - reset and a0 sources depend on mode
// - top select: end-of-count or nmi pin
// - a0 select: end-of-count or interrupt pin
// - both select zero: only a0 taken
// - counter bytes accessible while running
// - prescaler divides 1..256; resets ff
// - bit7 runs, bit6 single mode
// - bits 5:4 choose input mode
// - bit3 enables external input section
// - bit2 toggle or copy level at end
// - output level bit resets to one
// - bit0 enables output, else pin high
// - clearing enable_n enters watchdog, sticky
// - strap low forces watchdog, bit ignored
// - end of count at counter zero
// - aah then 55h reloads watchdog counter
// - watchdog counts core clock over four
// - prescaler immediate; counter at end
module twu_timer_watchdog_unit (
   input wire logic pclk,
   input wire logic presetn,
   input wire twu_pkg::twu_apb_req_s apb_req,   // apb request group
   output twu_pkg::twu_apb_rsp_s apb_rsp,       // apb answer group
   input wire logic count_input_pin,            // external count/gate input
   input wire logic hw_sw_guard_strap,          // low: hardware watchdog
   input wire logic ext_irq_pin,                // external pin for channel a0
   input wire logic nmi_pin,                    // non-maskable pin for top level
   input wire logic timer_irq_enable,           // end-of-count interrupt enable
   input wire logic halt_exec,                  // cpu executes halt
   input wire logic irq_ack_a0,                 // cpu acknowledges channel a0
   input wire logic irq_ack_top,                // cpu acknowledges top level
   output logic wave_output_pin,                // waveform output
   output logic ext_irq_channel_a0,             // channel a0 request
   output logic top_level_irq,                  // top-level request
   output logic system_reset_req,               // watchdog system reset pulse
   output logic guard_reset_flag,               // clock flag bit 6 image
   output logic cpu_stall                       // halt stops execution and acks
);
   import twu_pkg::*;
   // ------------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------------
   function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
      hit = (a == {2'b00, idx, 2'b00});
   endfunction
   logic [7:0] ctl_q, wcr_q, eiv_q, pre_q, hi_q, lo_q, pend_q;
   logic [15:0] cnt_q;      // live down counter
   logic [7:0] psc_q;       // live prescaler count
   logic [1:0] div_q;       // core clock divider
   logic wave_q, guard_q, strap_q, strap_taken_q, reload_q, in_d1_q;
   logic armed_q;           // trigger seen while running, in any input mode
   logic fresh_q;           // counter byte written, not yet loaded
   twu_key_e key_q;
   twu_apb_rsp_s rsp_q;
   logic rst_q, flag_q, a0_q, top_q, stall_q, pin_q;
   wire acc = apb_req.psel && apb_req.penable;
   wire wr = acc && apb_req.pwrite;
   wire [7:0] wd = apb_req.pwdata[7:0];
   wire s_eiv = hit(apb_req.paddr, IDX_EXT_IRQ_VECTOR_SELECT);
   wire s_hi = hit(apb_req.paddr, IDX_COUNTER_HIGH_BYTE);
   wire s_lo = hit(apb_req.paddr, IDX_COUNTER_LOW_BYTE);
   wire s_pre = hit(apb_req.paddr, IDX_PRESCALER_VALUE);
   wire s_ctl = hit(apb_req.paddr, IDX_TIMER_CONTROL);
   wire s_wcr = hit(apb_req.paddr, IDX_WAIT_CONTROL);
   wire s_st = hit(apb_req.paddr, IDX_IRQ_STATUS);
   wire s_any = s_eiv | s_hi | s_lo | s_pre | s_ctl | s_wcr | s_st;
   // ------------------------------------------------------------------
   // mode and clocking
   // ------------------------------------------------------------------
   // hardware strap caught after reset release, never in reset branch
   wire hw_guard = strap_taken_q && !strap_q;
   wire guard_mode = guard_q || hw_guard;
   wire tick4 = (div_q == 2'(CORE_DIV - 1));
   wire in_fall = in_d1_q && !count_input_pin;
   wire twu_in_mode_e mode = twu_in_mode_e'(ctl_q[CTL_MODE_HI:CTL_MODE_LO]);
   wire ext_on = ctl_q[CTL_INPUT_ON];
   wire run_bit = ctl_q[CTL_RUN];
   // counting enable and clock source in timer mode
   wire base_tick = (ext_on && mode == twu_event_count) ? in_fall : tick4;
   wire gate_ok = !ext_on || (mode == twu_event_count) || (mode == twu_retrigger) ||
                  (mode == twu_gated && count_input_pin) || (mode == twu_trigger && armed_q);
   // watchdog: run always, internal clock, continuous; halt does not stop it
   wire cnt_tick = guard_mode ? tick4 : (run_bit && gate_ok && base_tick);
   wire psc_end = cnt_tick && (psc_q == 8'h00);
   wire eoc = psc_end && (cnt_q == 16'h0000);
   wire retrig = !guard_mode && run_bit && ext_on && mode == twu_retrigger && in_fall;
   wire key_done = wr && s_lo && key_q == twu_key_armed && wd == KEY_SECOND;
   // a stopped timer picks up a new constant when it is started again
   wire start = wr && s_ctl && wd[CTL_RUN] && !run_bit && !guard_mode;
   // strapped watchdog ignores the enable bit, so it gives no free reload
   wire guard_entry = wr && s_wcr && !wd[WCR_GUARD_EN_N] && !guard_mode;
   wire timer_evt = eoc && !guard_mode && timer_irq_enable;
   // hardware watchdog keeps the reset constant
   wire [15:0] load_val = hw_guard ? {RST_COUNTER_BYTE, RST_COUNTER_BYTE} : {hi_q, lo_q};
   wire [7:0] load_pre = pre_q;     // prescaler stays writable in every mode
   // ------------------------------------------------------------------
   // interrupt routing
   // ------------------------------------------------------------------
   wire a0_src = eiv_q[EIV_A0_SEL] ? ext_irq_pin : timer_evt;
   // when both selects are zero the end of count goes to a0 only
   wire top_src = eiv_q[EIV_TOP_SEL] ? nmi_pin :
                  (eiv_q[EIV_A0_SEL] ? timer_evt : 1'b0);
   wire sw_a0 = wr && s_st && wd[ST_A0_PEND];
   wire sw_top = wr && s_st && wd[ST_TOP_PEND];
   wire [7:0] rdata = s_eiv ? eiv_q : s_hi ? cnt_q[15:8] : s_lo ? cnt_q[7:0] :
                      s_pre ? pre_q : s_ctl ? ctl_q : s_wcr ? wcr_q :
                      s_st ? {5'h00, guard_mode, pend_q[1:0]} : 8'h00;
   // ------------------------------------------------------------------
   // register file writes
   // ------------------------------------------------------------------
   // control byte: single mode clears run at end of count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_q <= RST_TIMER_CONTROL;
         eiv_q <= RST_EXT_IRQ_VECTOR;
         pre_q <= RST_PRESCALER;
         hi_q <= RST_COUNTER_BYTE;
         lo_q <= RST_COUNTER_BYTE;
      end else begin
         if (wr && s_ctl) begin
            ctl_q <= wd;
         end else if (eoc && !guard_mode && ctl_q[CTL_SINGLE]) begin
            ctl_q[CTL_RUN] <= 1'b0;
         end
         if (wr && s_eiv) begin
            eiv_q <= {5'h00, wd[2:0]};
         end
         if (wr && s_pre) begin
            pre_q <= wd;
         end
         // of the counter constants only the prescaler changes once watchdog mode is on
         if (wr && s_hi && !guard_mode) begin
            hi_q <= wd;
         end
         if (wr && s_lo && !guard_mode) begin
            lo_q <= wd;
         end
      end
   end
   // watchdog enable latch; strap sampled once after release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wcr_q <= RST_WAIT_CONTROL;
         guard_q <= 1'b0;
         strap_q <= 1'b1;
         strap_taken_q <= 1'b0;
      end else begin
         if (!strap_taken_q) begin
            strap_q <= hw_sw_guard_strap;
            strap_taken_q <= 1'b1;
         end
         // set back to one is refused: once low stays low
         if (wr && s_wcr) begin
            wcr_q <= {1'b0, wd[WCR_GUARD_EN_N] & wcr_q[WCR_GUARD_EN_N], wd[5:0]};
         end
         if (wr && s_wcr && !wd[WCR_GUARD_EN_N] && !hw_guard) begin
            guard_q <= 1'b1;
         end
      end
   end
   // ------------------------------------------------------------------
   // counter, prescaler and divider
   // ------------------------------------------------------------------
   // new constants load at end of count or on restart; prescaler value reloads per wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= {RST_COUNTER_BYTE, RST_COUNTER_BYTE};
         psc_q <= RST_PRESCALER;
         div_q <= 2'b00;
         in_d1_q <= 1'b1;
         armed_q <= 1'b0;
         reload_q <= 1'b0;
         key_q <= twu_key_idle;
         fresh_q <= 1'b0;
      end else begin
         div_q <= tick4 ? 2'b00 : div_q + 2'b01;
         in_d1_q <= count_input_pin;
         armed_q <= run_bit && (armed_q || in_fall);
         reload_q <= 1'b0;
         if (wr && s_lo) begin
            key_q <= (wd == KEY_FIRST) ? twu_key_armed : twu_key_idle;
         end
         // a write in the end-of-count cycle wins: that value is not loaded yet
         if (wr && (s_hi || s_lo) && !guard_mode) begin
            fresh_q <= 1'b1;
         end else if (eoc || start) begin
            fresh_q <= 1'b0;
         end
         if (key_done || retrig || guard_entry || (start && fresh_q)) begin
            cnt_q <= load_val;
            psc_q <= load_pre;
         end else if (eoc) begin
            cnt_q <= load_val;
            psc_q <= load_pre;
         end else if (psc_end) begin
            cnt_q <= cnt_q - 16'h0001;
            psc_q <= pre_q;
         end else if (cnt_tick) begin
            psc_q <= (psc_q > pre_q) ? pre_q : psc_q - 8'h01;
         end
      end
   end
   // ------------------------------------------------------------------
   // output pin, interrupts, reset and halt
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wave_q <= 1'b1;
         pend_q <= 8'h00;
         a0_q <= 1'b0;
         top_q <= 1'b0;
         rst_q <= 1'b0;
         flag_q <= 1'b0;
         stall_q <= 1'b0;
         pin_q <= 1'b1;
         rsp_q <= '0;
      end else begin
         if (eoc && ctl_q[CTL_OUT_ON]) begin
            wave_q <= ctl_q[CTL_OUT_STYLE] ? ctl_q[CTL_OUT_LEVEL] : !wave_q;
         end
         // output disabled drives pin high for alternate use
         pin_q <= ctl_q[CTL_OUT_ON] ? wave_q : 1'b1;
         // set beats clear: a new event in the ack cycle stays pending
         pend_q[ST_A0_PEND] <= a0_src || sw_a0 || (pend_q[ST_A0_PEND] && !irq_ack_a0);
         pend_q[ST_TOP_PEND] <= top_src || sw_top || (pend_q[ST_TOP_PEND] && !irq_ack_top);
         a0_q <= a0_src || sw_a0 || (pend_q[ST_A0_PEND] && !irq_ack_a0);
         top_q <= top_src || sw_top || (pend_q[ST_TOP_PEND] && !irq_ack_top);
         rst_q <= eoc && guard_mode;
         flag_q <= flag_q || (eoc && guard_mode);
         stall_q <= halt_exec || (stall_q && !(wr && s_wcr));
         rsp_q.pready <= apb_req.psel && !apb_req.penable;
         rsp_q.pslverr <= apb_req.psel && !apb_req.penable && !s_any;
         rsp_q.prdata <= {24'h000000, rdata};
      end
   end
   assign wave_output_pin = pin_q;
   assign ext_irq_channel_a0 = a0_q;
   assign top_level_irq = top_q;
   assign system_reset_req = rst_q;
   assign guard_reset_flag = flag_q;
   assign cpu_stall = stall_q;
   assign apb_rsp = rsp_q;
   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   a_guard_reset: assert property (@(posedge pclk) disable iff (!presetn)
      eoc && guard_mode |=> system_reset_req && guard_reset_flag)
      else $error("watchdog end did not reset");
   a_guard_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      guard_q |=> guard_q)
      else $error("watchdog mode left");
   a_timer_no_reset: assert property (@(posedge pclk) disable iff (!presetn)
      !guard_mode && !$past(guard_mode) |-> !system_reset_req)
      else $error("reset in timer mode");
   a_both_zero_top: assert property (@(posedge pclk) disable iff (!presetn)
      eiv_q[2:1] == 2'b00 && !sw_top && !pend_q[1] |=> !top_level_irq)
      else $error("top level taken with both selects zero");
   a_eoc_a0: assert property (@(posedge pclk) disable iff (!presetn)
      timer_evt && !eiv_q[EIV_A0_SEL] |=> ext_irq_channel_a0)
      else $error("end of count lost on a0");
   a_sw_trap: assert property (@(posedge pclk) disable iff (!presetn)
      sw_a0 |=> ext_irq_channel_a0 ##0 pend_q[ST_A0_PEND])
      else $error("software trap missing");
   a_single_stop: assert property (@(posedge pclk) disable iff (!presetn)
      eoc && !guard_mode && ctl_q[CTL_SINGLE] && !(wr && s_ctl) |=> !ctl_q[CTL_RUN])
      else $error("single mode did not stop");
   a_out_off_high: assert property (@(posedge pclk) disable iff (!presetn)
      !ctl_q[CTL_OUT_ON] |=> wave_output_pin)
      else $error("disabled output not high");
   a_guard_runs: assert property (@(posedge pclk) disable iff (!presetn)
      guard_mode && tick4 |-> cnt_tick)
      else $error("watchdog not counting");
   c_guard_reset: cover property (@(posedge pclk) disable iff (!presetn) system_reset_req);
   c_key_reload: cover property (@(posedge pclk) disable iff (!presetn) key_done);
   c_timer_eoc: cover property (@(posedge pclk) disable iff (!presetn) timer_evt);
   c_pwm_edge: cover property (@(posedge pclk) disable iff (!presetn)
      eoc && ctl_q[CTL_OUT_STYLE] && ctl_q[CTL_OUT_ON]);
endmodule

/* verif/twu_pin_model.sv */
// far-side pin model: drives the count input of the timer/watchdog unit
`timescale 1ns/1ps
module twu_pin_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic fall_req,    // ask for one high-low-high event
   input wire logic hold_low,    // keep the pin low, gate closed
   output logic count_input_pin  // level seen by the unit
);
   // ----------------------------------------------------------------
   // event shaping
   // ----------------------------------------------------------------
   logic [2:0] low_q;  // cycles of low level still to show
   // low phase lasts four cycles so a synchronised input cannot miss it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_q <= 3'h0;
      end else if (fall_req) begin
         low_q <= 3'h4;
      end else if (low_q != 3'h0) begin
         low_q <= low_q - 3'h1;
      end
   end
   // idle level is high, so the only falling edge opens an event
   assign count_input_pin = ~hold_low & (low_q == 3'h0);
endmodule

/* verif/tb_timer_watchdog_unit.sv */
// testbench of the timer/watchdog unit: registers, timer, interrupts, watchdog
`timescale 1ns/1ps
module tb_timer_watchdog_unit;
   import twu_pkg::*;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   twu_apb_req_s req = '0;
   twu_apb_rsp_s rsp;
   logic strap = 1'b1, irq_pin = 1'b0, nmi = 1'b0, irq_en = 1'b0, halt = 1'b0;
   logic ack = 1'b0, fall_req = 1'b0, hold_low = 1'b0;
   logic cin, wave, a0, top, rst_req, flag, stall;
   logic [31:0] rd;
   logic err;
   int fails = 0, cmp_count = 0, t0, t1, t2, k, rst_seen = 0;
   // 40 MHz clock
   always #12.5 pclk = ~pclk;
   twu_timer_watchdog_unit uut (.pclk(pclk), .presetn(presetn), .apb_req(req),
      .apb_rsp(rsp), .count_input_pin(cin), .hw_sw_guard_strap(strap),
      .ext_irq_pin(irq_pin), .nmi_pin(nmi), .timer_irq_enable(irq_en),
      .halt_exec(halt), .irq_ack_a0(ack), .irq_ack_top(ack),
      .wave_output_pin(wave), .ext_irq_channel_a0(a0), .top_level_irq(top),
      .system_reset_req(rst_req), .guard_reset_flag(flag), .cpu_stall(stall));
   twu_pin_model pins (.pclk(pclk), .presetn(presetn), .fall_req(fall_req),
      .hold_low(hold_low), .count_input_pin(cin));
   // reset pulses are counted so a missing service shows as a number
   always @(negedge pclk) if (rst_req === 1'b1) rst_seen++;
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic test_done();
      if (fails == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one apb transfer; byte address is four times the register index
   task automatic xfer(input logic [7:0] idx, input logic w, input logic [7:0] d);
      logic got;
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {2'b00, idx, 2'b00},
               pwdata: {24'h0, d}};
      @(posedge pclk);
      req.penable <= 1'b1;
      // registered answer is settled mid-cycle and stands at the next rising edge
      do begin
         @(negedge pclk);
         got = rsp.pready;
         rd = rsp.prdata;
         err = rsp.pslverr;
         @(posedge pclk);
      end while (got !== 1'b1);
      req <= '0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      xfer(idx, 1'b1, d);
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
      xfer(idx, 1'b0, 8'h00);
      check(rd, {24'h0, exp});
   endtask
   // cycles between two toggles of the wave pin, bounded
   task automatic period(output int t);
      logic w0;
      int n;
      t = 0;
      n = 0;
      @(negedge pclk);
      w0 = wave;
      while (wave === w0 && n < 3000) begin
         @(negedge pclk);
         n++;
      end
      w0 = wave;
      while (wave === w0 && t < 3000) begin
         @(negedge pclk);
         t++;
      end
   endtask
   task automatic toggles(input int n, output int c);
      logic w0;
      c = 0;
      // let the registered pin follow a just-written enable first
      repeat (2) @(negedge pclk);
      repeat (n) begin
         w0 = wave;
         @(negedge pclk);
         if (wave !== w0) c++;
      end
   endtask
   // ----------------------------------------------------------------
   // watchdog of the run itself
   // ----------------------------------------------------------------
   initial begin
      tick(30000);
      fails++;
      test_done();
   end
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      tick(12);
      presetn <= 1'b1;
      tick(2);
      rdc(IDX_COUNTER_HIGH_BYTE, RST_COUNTER_BYTE);
      rdc(IDX_COUNTER_LOW_BYTE, RST_COUNTER_BYTE);
      rdc(IDX_PRESCALER_VALUE, RST_PRESCALER);
      rdc(IDX_TIMER_CONTROL, 8'h12);
      rdc(IDX_WAIT_CONTROL, 8'h7f);
      check(wave, 1'b1);
      xfer(8'h10, 1'b0, 8'h00);
      check(rd, 32'h0);
      check(err, 1'b1);
      // timer loaded before start, internal clock, toggle output
      wr(IDX_PRESCALER_VALUE, 8'h00);
      wr(IDX_COUNTER_HIGH_BYTE, 8'h00);
      wr(IDX_COUNTER_LOW_BYTE, 8'h03);
      wr(IDX_TIMER_CONTROL, 8'h83);
      period(t0);
      check(t0, (3 + 1) * CORE_DIV);
      wr(IDX_PRESCALER_VALUE, 8'h01);
      period(t1);
      check(t1, 2 * t0);
      wr(IDX_COUNTER_LOW_BYTE, 8'h07);
      period(t2);
      period(t2);
      check(t2, 2 * t1);
      wr(IDX_TIMER_CONTROL, 8'hc3);
      tick(300);
      rdc(IDX_TIMER_CONTROL, 8'h43);
      wr(IDX_TIMER_CONTROL, 8'h80);
      tick(2);
      check(wave, 1'b1);
      wr(IDX_TIMER_CONTROL, 8'h85);
      tick(200);
      check(wave, 1'b0);
      wr(IDX_TIMER_CONTROL, 8'h87);
      tick(200);
      check(wave, 1'b1);
      // interrupt routing; pending cleared before each select change
      wr(IDX_TIMER_CONTROL, 8'h80);
      irq_en <= 1'b1;
      wr(IDX_EXT_IRQ_VECTOR_SELECT, 8'h00);
      tick(200);
      check({a0, top}, 2'b10);
      irq_en <= 1'b0;
      ack <= 1'b1;
      tick(1);
      ack <= 1'b0;
      tick(200);
      check({a0, top}, 2'b00);
      wr(IDX_EXT_IRQ_VECTOR_SELECT, 8'h02);
      irq_en <= 1'b1;
      tick(200);
      check({a0, top}, 2'b01);
      irq_pin <= 1'b1;
      tick(1);
      irq_pin <= 1'b0;
      tick(3);
      check(a0, 1'b1);
      irq_en <= 1'b0;
      ack <= 1'b1;
      tick(1);
      ack <= 1'b0;
      wr(IDX_EXT_IRQ_VECTOR_SELECT, 8'h06);
      irq_en <= 1'b1;
      tick(200);
      check({a0, top}, 2'b00);
      nmi <= 1'b1;
      tick(1);
      nmi <= 1'b0;
      tick(3);
      check(top, 1'b1);
      ack <= 1'b1;
      tick(1);
      ack <= 1'b0;
      wr(IDX_IRQ_STATUS, 8'h03);
      tick(3);
      check({a0, top}, 2'b11);
      // input modes: pin idle high, then four falling edges
      wr(IDX_COUNTER_LOW_BYTE, 8'h01);
      wr(IDX_PRESCALER_VALUE, 8'h00);
      for (int m = 0; m < 4; m++) begin
         wr(IDX_TIMER_CONTROL, 8'h00);
         wr(IDX_TIMER_CONTROL, 8'h8b | 8'(m << 4));
         toggles(100, k);
         check(k > 0, m % 2);
         fork
            toggles(60, k);
            repeat (4) begin
               fall_req <= 1'b1;
               tick(1);
               fall_req <= 1'b0;
               tick(12);
            end
         join
         check(k > 0, 1);
      end
      hold_low <= 1'b1;
      wr(IDX_TIMER_CONTROL, 8'h93);
      toggles(100, k);
      check(k > 0, 1);
      hold_low <= 1'b0;
      // watchdog: stopped, output off, serviced, then halted
      wr(IDX_TIMER_CONTROL, 8'h00);
      wr(IDX_COUNTER_LOW_BYTE, 8'h10);
      tick(200);
      ack <= 1'b1;
      tick(1);
      ack <= 1'b0;
      wr(IDX_EXT_IRQ_VECTOR_SELECT, 8'h00);
      wr(IDX_WAIT_CONTROL, 8'h3f);
      wr(IDX_WAIT_CONTROL, 8'h7f);
      xfer(IDX_WAIT_CONTROL, 1'b0, 8'h00);
      check(rd[WCR_GUARD_EN_N], 1'b0);
      xfer(IDX_IRQ_STATUS, 1'b0, 8'h00);
      check(rd[ST_GUARD_MODE], 1'b1);
      repeat (8) begin
         wr(IDX_COUNTER_LOW_BYTE, KEY_FIRST);
         wr(IDX_COUNTER_LOW_BYTE, KEY_SECOND);
         tick(20);
      end
      check(rst_seen, 0);
      halt <= 1'b1;
      tick(3);
      check(stall, 1'b1);
      tick(400);
      check(rst_seen > 0, 1);
      check(flag, 1'b1);
      check({a0, top}, 2'b00);
      // hardware strap low at release forces watchdog mode
      presetn <= 1'b0;
      strap <= 1'b0;
      halt <= 1'b0;
      tick(3);
      presetn <= 1'b1;
      tick(2);
      xfer(IDX_IRQ_STATUS, 1'b0, 8'h00);
      check(rd[ST_GUARD_MODE], 1'b1);
      test_done();
   end
endmodule
